// >>> lsu_defines.vh
// Constants for the link status upper field encoder: register map, field
// positions, reset values and speed codes.
// Assumes inclusion by bare name from every design file of the block.
`ifndef LSU_DEFINES_VH
`define LSU_DEFINES_VH

// Register byte offsets on the AHB-Lite slave
`define LSU_OFS_CTRL      8'h00
`define LSU_OFS_SNAP_CMD  8'h04
`define LSU_OFS_LIVE      8'h08
`define LSU_OFS_SNAP      8'h0C
`define LSU_OFS_RAW       8'h10
`define LSU_OFS_COUNT     8'h14

// Control register fields and reset value
`define LSU_CTRL_REV_LO   0
`define LSU_CTRL_REV_HI   1
`define LSU_CTRL_MOD_EN   2
`define LSU_CTRL_XSPD_EN  3
`define LSU_CTRL_AUTO     4
`define LSU_CTRL_W        5
`define LSU_CTRL_RST      5'h1E

// Protocol revision codes held in the control register
`define LSU_REV_1_0       2'h0
`define LSU_REV_1_1       2'h1
`define LSU_REV_1_2       2'h2

// Link status word bit positions
`define LSU_B_TEN_HALF    15
`define LSU_B_TX_PAUSE    16
`define LSU_B_RX_PAUSE    17
`define LSU_B_PPAUSE_LO   18
`define LSU_B_PPAUSE_HI   19
`define LSU_B_SERDES      20
`define LSU_B_VEND_VALID  21
`define LSU_B_MOD_LO      22
`define LSU_B_MOD_HI      23
`define LSU_B_XSPD_LO     24
`define LSU_B_XSPD_HI     31

// Field encodings
`define LSU_MOD_NONE      2'h0
`define LSU_MOD_NRZ       2'h1
`define LSU_MOD_PAM4      2'h2
`define LSU_XSPD_NONE     8'h00
`define LSU_XSPD_FIRST    8'h01
`define LSU_XSPD_1G_NONT  8'h10
`define LSU_XSPD_200G     8'h11
`define LSU_XSPD_400G     8'h12
`define LSU_XSPD_LAST     8'h13

// AHB-Lite encodings
`define LSU_HTRANS_NONSEQ 2'h2
`define LSU_HSIZE_WORD    3'h2

`endif

// >>> lsu_encoder.v
// Combinational encoder of link status word bits 31..15.
// Assumes its inputs are already synchronous to the caller's clock.
`default_nettype none
`include "lsu_defines.vh"

module lsu_encoder (
  input  wire        is_ethernet,
  input  wire        serializer_direct_attach_flag,
  input  wire        an_enable,
  input  wire        an_complete,
  input  wire        partner_ten_meg_half_cap,
  input  wire        tx_pause_en,
  input  wire        rx_pause_en,
  input  wire        partner_pause_sym,
  input  wire        partner_pause_asym,
  input  wire        vendor_speed_valid,
  input  wire [1:0]  mod_sel,
  input  wire [7:0]  resolved_speed,
  input  wire [1:0]  rev,
  input  wire        mod_en,
  input  wire        xspd_en,
  output reg  [31:0] word
);

  wire       an_good;
  wire       spd_ok;
  reg  [1:0] mod_fld;
  reg  [7:0] xspd_fld;

  // Partner abilities only mean something after a completed negotiation
  assign an_good = is_ethernet & ~serializer_direct_attach_flag & an_enable & an_complete;
  // Only codes 0x01..0x13 are legal; twisted-pair codes start at 0x01
  assign spd_ok  = (resolved_speed >= `LSU_XSPD_FIRST) &&
                   (resolved_speed <= `LSU_XSPD_LAST);

  always @* begin
    mod_fld = `LSU_MOD_NONE;
    if (is_ethernet && mod_en && rev == `LSU_REV_1_2 &&
        (mod_sel == `LSU_MOD_NRZ || mod_sel == `LSU_MOD_PAM4)) begin
      mod_fld = mod_sel;
    end
  end

  always @* begin
    xspd_fld = `LSU_XSPD_NONE;
    // Revision 1.0 leaves the field reserved, so it stays zero
    if (xspd_en && rev != `LSU_REV_1_0 && an_complete &&
        !serializer_direct_attach_flag && spd_ok) begin
      xspd_fld = resolved_speed;
    end
  end

  always @* begin
    word = 32'h0000_0000;
    word[`LSU_B_TEN_HALF]   = an_good & partner_ten_meg_half_cap;
    word[`LSU_B_TX_PAUSE]   = is_ethernet & tx_pause_en;
    word[`LSU_B_RX_PAUSE]   = is_ethernet & rx_pause_en;
    word[`LSU_B_PPAUSE_LO]  = an_good & partner_pause_sym;
    word[`LSU_B_PPAUSE_HI]  = an_good & partner_pause_asym;
    word[`LSU_B_SERDES]     = serializer_direct_attach_flag;
    word[`LSU_B_VEND_VALID] = vendor_speed_valid;
    word[`LSU_B_MOD_HI:`LSU_B_MOD_LO]   = mod_fld;
    word[`LSU_B_XSPD_HI:`LSU_B_XSPD_LO] = xspd_fld;
  end

endmodule
`default_nettype wire

// >>> lsu_top.v
// Link status upper field encoder with an AHB-Lite register slave.
// Assumes link-state inputs synchronous to clk and a single AHB-Lite master.
`default_nettype none
`include "lsu_defines.vh"

// Notes on behaviour
// - Bit 15 is set when the partner advertised 10 Mb half-duplex ability.
// - The 10 Mb half-duplex bit only counts on Ethernet, no serializer, negotiation on and done.
// - Bit 16 shows pause transmit enable, and is 0 when disabled or not Ethernet.
// - Bit 17 shows pause receive enable, and is 0 when disabled or not Ethernet.
// - Bits 19..18 carry partner pause ability, only after completed negotiation without serializer.
// - Bit 20 is 1 when the serializer is a direct-attach interface.
// - Bit 21 is 1 only while vendor link settings are valid.
// - Bits 23..22 give 01 for NRZ and 10 for PAM-4 on Ethernet, otherwise 00.
// - The modulation field is offered only at revision 1.2 and is reserved below it.
// - The extended speed code is optional at 1.1 and 1.2 and reserved at 1.0.
// - The speed code is zero without completed negotiation, with the serializer, or with no match.
// - Twisted-pair speed codes start at 0x01 for 10 Mb half-duplex and ascend.
// - Non-twisted-pair speeds use 0x10, 0x11, 0x12, 0x13 and the other listed codes.
// - Codes 0x14 to 0xFF are never emitted.
module lsu_top (
  input  wire        clk,
  input  wire        arst_n,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Link state from PHY and MAC
  input  wire        is_ethernet,
  input  wire        serializer_direct_attach_flag,
  input  wire        an_enable,
  input  wire        an_complete,
  input  wire        partner_ten_meg_half_cap,
  input  wire        tx_pause_en,
  input  wire        rx_pause_en,
  input  wire        partner_pause_sym,
  input  wire        partner_pause_asym,
  input  wire        vendor_speed_valid,
  input  wire [1:0]  mod_sel,
  input  wire [7:0]  resolved_speed,
  // Response builder side
  input  wire        rsp_req,
  output reg  [31:0] rsp_word,
  output reg         rsp_valid
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_WR   = 2'h1;
  localparam [1:0] ST_RD1  = 2'h2;
  localparam [1:0] ST_RD2  = 2'h3;

  reg  [1:0]              st_r;
  reg  [1:0]              st_nxt;
  reg  [7:0]              addr_r;
  reg                     word_ok_r;
  reg  [`LSU_CTRL_W-1:0]  ctrl_r;
  reg  [31:0]             live_r;
  reg  [31:0]             snap_r;
  reg  [15:0]             count_r;
  reg  [31:0]             rd_mux;
  wire [31:0]             enc_word;
  wire                    acc;
  wire                    wr_commit;
  wire                    sw_snap;
  wire                    hw_snap;
  wire                    take_snap;
  wire [15:0]             raw_bits;

  lsu_encoder u_enc (
    .is_ethernet                   (is_ethernet),
    .serializer_direct_attach_flag (serializer_direct_attach_flag),
    .an_enable                     (an_enable),
    .an_complete                   (an_complete),
    .partner_ten_meg_half_cap      (partner_ten_meg_half_cap),
    .tx_pause_en                   (tx_pause_en),
    .rx_pause_en                   (rx_pause_en),
    .partner_pause_sym             (partner_pause_sym),
    .partner_pause_asym            (partner_pause_asym),
    .vendor_speed_valid            (vendor_speed_valid),
    .mod_sel                       (mod_sel),
    .resolved_speed                (resolved_speed),
    .rev                           (ctrl_r[`LSU_CTRL_REV_HI:`LSU_CTRL_REV_LO]),
    .mod_en                        (ctrl_r[`LSU_CTRL_MOD_EN]),
    .xspd_en                       (ctrl_r[`LSU_CTRL_XSPD_EN]),
    .word                          (enc_word)
  );

  // Address phase is taken when the bus is ready and a NONSEQ targets us
  assign acc       = hsel & hready & (htrans == `LSU_HTRANS_NONSEQ);
  // Reads cost one wait state so a read right after a write sees new data
  assign hreadyout = (st_r != ST_RD1);
  assign hresp     = 1'b0;
  assign wr_commit = (st_r == ST_WR) & word_ok_r;

  always @* begin
    st_nxt = st_r;
    case (st_r)
      ST_IDLE, ST_WR, ST_RD2: begin
        if (acc) begin
          st_nxt = hwrite ? ST_WR : ST_RD1;
        end else begin
          st_nxt = ST_IDLE;
        end
      end
      ST_RD1: begin
        st_nxt = ST_RD2;
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r      <= ST_IDLE;
      addr_r    <= 8'h00;
      word_ok_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      if (acc) begin
        addr_r    <= haddr[7:0];
        // Sub-word writes are ignored; the block only holds whole words
        word_ok_r <= (hsize == `LSU_HSIZE_WORD) && (haddr[1:0] == 2'b00);
      end
    end
  end

  // Control register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `LSU_CTRL_RST;
    end else if (wr_commit && addr_r == `LSU_OFS_CTRL) begin
      ctrl_r <= hwdata[`LSU_CTRL_W-1:0];
    end
  end

  // Snapshot on a response request or a software command
  assign sw_snap   = wr_commit && (addr_r == `LSU_OFS_SNAP_CMD) && hwdata[0];
  assign hw_snap   = rsp_req & ctrl_r[`LSU_CTRL_AUTO];
  assign take_snap = sw_snap | hw_snap;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      live_r    <= 32'h0000_0000;
      snap_r    <= 32'h0000_0000;
      count_r   <= 16'h0000;
      rsp_word  <= 32'h0000_0000;
      rsp_valid <= 1'b0;
    end else begin
      live_r    <= enc_word;
      rsp_valid <= hw_snap;
      if (take_snap) begin
        // Encoder output of this very cycle, not a stale copy
        snap_r  <= enc_word;
        count_r <= count_r + 16'h0001;
      end
      if (hw_snap) begin
        rsp_word <= enc_word;
      end
    end
  end

  assign raw_bits = {2'b00, resolved_speed[3:0], mod_sel, vendor_speed_valid,
                     partner_pause_asym, partner_pause_sym, rx_pause_en,
                     tx_pause_en, partner_ten_meg_half_cap, an_complete,
                     an_enable};

  always @* begin
    case (addr_r)
      `LSU_OFS_CTRL:  rd_mux = {{(32-`LSU_CTRL_W){1'b0}}, ctrl_r};
      `LSU_OFS_LIVE:  rd_mux = live_r;
      `LSU_OFS_SNAP:  rd_mux = snap_r;
      `LSU_OFS_RAW:   rd_mux = {resolved_speed, 6'h00, serializer_direct_attach_flag,
                                is_ethernet, raw_bits};
      `LSU_OFS_COUNT: rd_mux = {16'h0000, count_r};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (st_r == ST_RD1) begin
      hrdata <= rd_mux;
    end
  end

endmodule
`default_nettype wire

// >>> lsu_properties.sv
// Checker of the link status word against the link inputs.
// Assumes a bind onto lsu_top; sees its ports only.
`default_nettype none
module lsu_properties (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        is_ethernet,
  input wire logic        serializer_direct_attach_flag,
  input wire logic        an_enable,
  input wire logic        an_complete,
  input wire logic        partner_ten_meg_half_cap,
  input wire logic        tx_pause_en,
  input wire logic        rx_pause_en,
  input wire logic        partner_pause_sym,
  input wire logic        partner_pause_asym,
  input wire logic        vendor_speed_valid,
  input wire logic [7:0]  resolved_speed,
  input wire logic        rsp_req,
  input wire logic [31:0] rsp_word,
  input wire logic        rsp_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  wire logic ok = is_ethernet & ~serializer_direct_attach_flag & an_enable & an_complete;
  wire logic th = ok & partner_ten_meg_half_cap;
  wire logic tx = is_ethernet & tx_pause_en;
  wire logic rx = is_ethernet & rx_pause_en;
  wire logic [1:0] pp = {ok & partner_pause_asym, ok & partner_pause_sym};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  valid_cause_a: assert property (rsp_valid |-> $past(rsp_req))
    else $error("valid without request");
  ten_half_a: assert property (rsp_valid |-> rsp_word[15] == $past(th))
    else $error("bit 15 wrong");
  tx_pause_a: assert property (rsp_valid |-> rsp_word[16] == $past(tx))
    else $error("bit 16 wrong");
  rx_pause_a: assert property (rsp_valid |-> rsp_word[17] == $past(rx))
    else $error("bit 17 wrong");
  partner_pause_a: assert property (rsp_valid |-> rsp_word[19:18] == $past(pp))
    else $error("bits 19..18 wrong");
  serdes_bit_a: assert property (rsp_valid |-> rsp_word[20] == $past(serializer_direct_attach_flag))
    else $error("bit 20 wrong");
  vendor_bit_a: assert property (rsp_valid |-> rsp_word[21] == $past(vendor_speed_valid))
    else $error("bit 21 wrong");
  mod_code_a: assert property (rsp_valid |-> rsp_word[23:22] != 2'h3)
    else $error("reserved modulation");
  mod_non_eth_a: assert property (rsp_valid && !$past(is_ethernet) |-> rsp_word[23:22] == 2'h0)
    else $error("modulation on non-Ethernet link");
  speed_serdes_a: assert property (rsp_valid && $past(serializer_direct_attach_flag) |-> rsp_word[31:24] == 8'h00)
    else $error("speed with serializer flag");
  speed_zero_a: assert property (rsp_valid && !$past(an_complete) |-> rsp_word[31:24] == 8'h00)
    else $error("speed without negotiation");
  speed_range_a: assert property (rsp_valid |-> rsp_word[31:24] <= 8'h13)
    else $error("reserved speed code");
  speed_value_a: assert property (rsp_valid && rsp_word[31:24] != 8'h00 |-> rsp_word[31:24] == $past(resolved_speed))
    else $error("speed code wrong");
endmodule
bind lsu_top lsu_properties i_lsu_properties (.clk(clk), .arst_n(arst_n),
  .is_ethernet(is_ethernet), .serializer_direct_attach_flag(serializer_direct_attach_flag),
  .an_enable(an_enable), .an_complete(an_complete),
  .partner_ten_meg_half_cap(partner_ten_meg_half_cap), .tx_pause_en(tx_pause_en),
  .rx_pause_en(rx_pause_en), .partner_pause_sym(partner_pause_sym),
  .partner_pause_asym(partner_pause_asym), .vendor_speed_valid(vendor_speed_valid),
  .resolved_speed(resolved_speed), .rsp_req(rsp_req), .rsp_word(rsp_word),
  .rsp_valid(rsp_valid));
`default_nettype wire

// >>> lsu_mc_model.sv
// Management controller model: asks for one link status response.
// Assumes the answer comes one cycle after the request edge.
`default_nettype none
module lsu_mc_model (
  input  wire logic clk,
  input  wire logic rsp_valid,
  output var  logic rsp_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial rsp_req = 1'b0;
  task automatic ask(output logic got);
    @(posedge clk) rsp_req <= 1'b1;
    @(posedge clk) rsp_req <= 1'b0;
    // Mid-cycle look: the pulse stands for this one cycle only
    @(negedge clk) got = (rsp_valid === 1'b1);
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// >>> lsu_tb_top.sv
// Testbench for lsu_top: link inputs, AHB-Lite registers, responses.
// Assumes lsu_mc_model and the bound checker are compiled with it.
`default_nettype none
module lsu_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [19:0] lk = 20'h0_0000;
  logic [4:0]  ctrl = 5'h1E;
  wire         hreadyout;
  wire         hresp;
  wire         rsp_req;
  wire         rsp_valid;
  wire  [31:0] hrdata;
  wire  [31:0] rsp_word;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  always #2 clk = ~clk;
  lsu_top i_lsu_top (.clk(clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .is_ethernet(lk[19]),
    .serializer_direct_attach_flag(lk[18]), .an_enable(lk[17]), .an_complete(lk[16]),
    .partner_ten_meg_half_cap(lk[15]), .tx_pause_en(lk[14]), .rx_pause_en(lk[13]),
    .partner_pause_sym(lk[12]), .partner_pause_asym(lk[11]), .vendor_speed_valid(lk[10]),
    .mod_sel(lk[9:8]), .resolved_speed(lk[7:0]), .rsp_req(rsp_req), .rsp_word(rsp_word),
    .rsp_valid(rsp_valid));
  lsu_mc_model i_lsu_mc_model (.clk(clk), .rsp_valid(rsp_valid), .rsp_req(rsp_req));
  function automatic logic [31:0] exp_word(input logic [19:0] v, input logic [4:0] c);
    logic        ok;
    logic [31:0] w;
    ok = v[19] & ~v[18] & v[17] & v[16];
    w = {10'h000, v[10], v[18], ok & v[11], ok & v[12], v[19] & v[13], v[19] & v[14],
         ok & v[15], 15'h0000};
    if (c[1:0] == 2'h2 && c[2] && v[19] && (v[9:8] == 2'h1 || v[9:8] == 2'h2)) begin
      w[23:22] = v[9:8];
    end
    if (c[1:0] != 2'h0 && c[3] && v[16] && !v[18] && v[7:0] != 8'h00 && v[7:0] <= 8'h13) begin
      w[31:24] = v[7:0];
    end
    return w;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Entered and left at a rising edge, so transfers run back to back
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    do @(negedge clk); while (hreadyout !== 1'b1);
    @(posedge clk);
    htrans <= 2'h0;
    hwdata <= d;
    do @(negedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0000_0000, hresp}, 32'h0000_0000);
    @(posedge clk);
  endtask
  task automatic ask_chk;
    logic got;
    i_lsu_mc_model.ask(got);
    chk({31'h0000_0000, got}, 32'h0000_0001);
    chk(rsp_word, exp_word(lk, ctrl));
  endtask
  task automatic t_fields;
    logic [19:0] tbl [7] = '{20'hB_F501, 20'hF_F510, 20'h3_EA13, 20'hA_B912,
                             20'hB_DF14, 20'hB_6A13, 20'h9_FD07};
    logic [31:0] r;
    foreach (tbl[i]) begin
      lk <= tbl[i];
      @(posedge clk);
      ask_chk();
    end
    ahb(1'b0, 8'h08, 32'h0000_0000, r);
    chk(r, exp_word(lk, ctrl));
  endtask
  task automatic t_rev;
    logic [31:0] r;
    logic        got;
    lk <= 20'hB_F613;
    for (int i = 0; i < 3; i++) begin
      ctrl = {3'h7, i[1:0]};
      ahb(1'b1, 8'h00, {27'h000_0000, ctrl}, r);
      ask_chk();
    end
    ahb(1'b0, 8'h20, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    ahb(1'b1, 8'h00, 32'h0000_000E, r);
    i_lsu_mc_model.ask(got);
    chk({31'h0000_0000, got}, 32'h0000_0000);
  endtask
  // Ten responses were taken so far; auto snapshot is now off
  task automatic t_regs;
    logic [31:0] r;
    ahb(1'b1, 8'h04, 32'h0000_0001, r);
    ahb(1'b0, 8'h0C, 32'h0000_0000, r);
    chk(r, exp_word(lk, 5'h0E));
    ahb(1'b0, 8'h14, 32'h0000_0000, r);
    chk(r, 32'h0000_000B);
    ahb(1'b0, 8'h04, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    ahb(1'b0, 8'h10, 32'h0000_0000, r);
    chk(r, {lk[7:0], 6'h00, lk[18], lk[19], 2'b00, lk[3:0], lk[9:8], lk[10], lk[11],
            lk[12], lk[13], lk[14], lk[15], lk[16], lk[17]});
  endtask
  task automatic results;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_fields();
    t_rev();
    t_regs();
    results();
  end
  // Whole run needs about seventy-five cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_errors++;
      results();
    end
  end
endmodule
`default_nettype wire
